//--- core/dics_map.svh
// Constants for the digital input channel scanner: addresses, fields, resets
`ifndef DICS_MAP_SVH
`define DICS_MAP_SVH
// ----------------------------------------
// Command decode
// ----------------------------------------
`define DICS_AREA        5'h0B
`define DICS_MOD_DSW_LO  7'h00
`define DICS_MOD_DSW_HI  7'h01
`define DICS_MOD_PI_LO   7'h02
`define DICS_MOD_PI_HI   7'h19
`define DICS_MOD_GRP_LO  7'h40
`define DICS_MOD_GRP_HI  7'h7F
// ----------------------------------------
// Status word layout and reset
// ----------------------------------------
`define DICS_DSW_PAR     0
`define DICS_DSW_PROT    1
`define DICS_DSW_DONE    2
`define DICS_DSW_BUSY    3
`define DICS_DSW_REJ     4
`define DICS_DSW_CAR     5
`define DICS_DSW_RESET   16'h0000
// ----------------------------------------
// Table header word and read mode
// ----------------------------------------
`define DICS_HDR_IRQ     15
`define DICS_HDR_CHAIN   14
`define DICS_CNT_W       13
`define DICS_GRP_W       7
`define DICS_SYNC_BIT    2
`endif

//--- core/dics_pkg.sv
// Types shared by the digital input channel scanner
`include "dics_map.svh"
package dics_pkg;
   // ----------------------------------------
   // Commands and answers
   // ----------------------------------------
   typedef enum logic [1:0] {FN_READ, FN_SENSE, FN_INIT, FN_HALT} dics_func_type;
   typedef enum logic [2:0] {S_IDLE, S_HDR, S_GRP, S_SYNC, S_CAP, S_WR, S_CHAIN, S_CAR} dics_state_type;
   typedef struct packed {
      dics_func_type     func;
      logic [4:0]        area;
      logic [6:0]        modifier;
      logic [2:0]        rmode;
      logic [15:0]       addr;
      logic              b15;
   } dics_cmd_type;
   typedef struct packed {
      logic              valid;
      logic              reject;
      logic [15:0]       data;
   } dics_rsp_type;
   // ----------------------------------------
   // Cycle steal port
   // ----------------------------------------
   typedef struct packed {
      logic              req;
      logic              we;
      logic [15:0]       addr;
      logic [15:0]       wdata;
   } dics_mreq_type;
   typedef struct packed {
      logic              gnt;
      logic [15:0]       rdata;
      logic              par_err;
      logic              prot_err;
   } dics_mrsp_type;
   // ----------------------------------------
   // Whole module state
   // ----------------------------------------
   typedef struct packed {
      dics_state_type    state;
      logic [2:0]        rmode;
      logic [15:0]       ptr;
      logic [`DICS_CNT_W-1:0] cnt;
      logic              sc_irq;
      logic              sc_chain;
      logic [`DICS_GRP_W-1:0] grp;
      logic [`DICS_GRP_W-1:0] sel;
      logic [15:0]       data;
      logic              direct_program_transfer;
      logic              dpc_rej;
      logic              grp_rd;
      logic [2:0]        sync_ff;
      logic              sync_lvl;
      logic              sync_pend;
      logic              par;
      logic              prot;
      logic              done;
      logic              rej;
      logic              carf;
      dics_rsp_type      rsp;
   } dics_st_type;
endpackage : dics_pkg

//--- core/dics_scanner.sv
// Digital input channel scanner: direct reads, table driven cycle steal scans
`timescale 1ns/10ps
module dics_scanner
   import dics_pkg::*;
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_b,
   // Processor commands
   input  wire logic          cmd_valid,
   input  wire dics_cmd_type  cmd,
   output dics_rsp_type       rsp,
   input  wire logic          cpu_parity_err,
   output logic               cpu_hold,
   output logic               scan_irq,
   // Cycle steal channel
   output dics_mreq_type      mem_o,
   input  wire dics_mrsp_type mem_i,
   // Field inputs
   output logic [6:0]         group_sel,
   output logic               group_rd,
   input  wire logic [15:0]   group_data,
   input  wire logic          ext_sync
);
   dics_st_type st_r;
   dics_st_type st_nxt;
   logic        busy;
   logic        sync_mode;
   logic        hit;
   logic        is_dsw;
   logic        is_grp;
   logic        is_pi;
   logic        rd_acc;
   logic        sync_rise;
   logic        end_tbl;
   logic        mem_err;
   logic [15:0] input_device_status_word;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign busy      = (st_r.state != S_IDLE);
   assign sync_mode = st_r.rmode[`DICS_SYNC_BIT];
   assign hit       = cmd_valid && (cmd.area == `DICS_AREA);
   assign is_dsw    = (cmd.modifier <= `DICS_MOD_DSW_HI);
   assign is_grp    = (cmd.modifier >= `DICS_MOD_GRP_LO);
   assign is_pi     = (cmd.modifier >= `DICS_MOD_PI_LO) && (cmd.modifier <= `DICS_MOD_PI_HI);
   assign rd_acc    = hit && ((cmd.func == FN_READ) || (cmd.func == FN_SENSE)) && !is_dsw;
   // Third and second stage agree before a change counts
   assign sync_rise = (st_r.sync_ff[1] == st_r.sync_ff[2]) && st_r.sync_ff[2] && !st_r.sync_lvl;
   assign mem_err   = mem_o.req && mem_i.gnt && (mem_i.par_err || mem_i.prot_err);

   always_comb begin
      input_device_status_word = `DICS_DSW_RESET;
      input_device_status_word[`DICS_DSW_PAR]  = st_r.par;
      input_device_status_word[`DICS_DSW_PROT] = st_r.prot;
      input_device_status_word[`DICS_DSW_DONE] = st_r.done;
      input_device_status_word[`DICS_DSW_BUSY] = busy;
      input_device_status_word[`DICS_DSW_REJ]  = st_r.rej;
      input_device_status_word[`DICS_DSW_CAR]  = st_r.carf;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt        = st_r;
      end_tbl       = 1'h0;
      st_nxt.grp_rd = 1'h0;
      st_nxt.direct_program_transfer    = 1'h0;
      st_nxt.rsp    = '0;
      st_nxt.sync_ff = {st_r.sync_ff[1:0], ext_sync};
      if (st_r.sync_ff[1] == st_r.sync_ff[2]) begin
         st_nxt.sync_lvl = st_r.sync_ff[2];
      end
      // Clears come first so that a same-cycle event wins
      if (hit && (cmd.func == FN_SENSE) && is_dsw && cmd.b15) begin
         st_nxt.done = 1'h0;
         st_nxt.rej  = 1'h0;
      end
      if (st_r.direct_program_transfer) begin
         st_nxt.rsp.valid  = 1'h1;
         st_nxt.rsp.reject = st_r.dpc_rej;
         st_nxt.rsp.data   = group_data;
      end
      case (st_r.state)
         S_IDLE: begin
         end
         S_HDR: begin
            if (mem_i.gnt) begin
               st_nxt.cnt      = mem_i.rdata[`DICS_CNT_W-1:0];
               st_nxt.sc_irq   = mem_i.rdata[`DICS_HDR_IRQ];
               st_nxt.sc_chain = mem_i.rdata[`DICS_HDR_CHAIN];
               st_nxt.ptr      = st_r.ptr + 16'h0001;
               st_nxt.state    = S_GRP;
               if (mem_i.rdata[`DICS_CNT_W-1:0] == '0) begin
                  st_nxt.sc_irq   = 1'h0;
                  st_nxt.sc_chain = mem_i.rdata[`DICS_HDR_CHAIN];
                  end_tbl         = 1'h1;
               end
            end
         end
         S_GRP: begin
            if (mem_i.gnt) begin
               st_nxt.grp   = mem_i.rdata[`DICS_GRP_W-1:0];
               st_nxt.ptr   = st_r.ptr + 16'h0001;
               st_nxt.state = S_SYNC;
            end
         end
         S_SYNC: begin
            // A pending direct read owns the group select this cycle
            if ((!sync_mode || st_r.sync_pend) && !st_r.direct_program_transfer && !rd_acc) begin
               st_nxt.sync_pend = 1'h0;
               st_nxt.sel       = st_r.grp;
               st_nxt.grp_rd    = 1'h1;
               st_nxt.state     = S_CAP;
            end
         end
         S_CAP: begin
            // Interrupt words in a scan read as blank
            st_nxt.data  = (st_r.sel >= `DICS_MOD_GRP_LO) ? group_data : 16'h0000;
            st_nxt.state = S_WR;
         end
         S_WR: begin
            if (mem_i.gnt) begin
               st_nxt.ptr = st_r.ptr + 16'h0001;
               st_nxt.cnt = st_r.cnt - `DICS_CNT_W'(1);
               if (st_r.cnt == `DICS_CNT_W'(1)) begin
                  end_tbl = 1'h1;
               end else if (st_r.rmode[1:0] == 2'h0) begin
                  st_nxt.state = S_GRP;
               end else if (st_r.rmode[1:0] == 2'h1) begin
                  st_nxt.grp   = st_r.grp + `DICS_GRP_W'(1);
                  st_nxt.state = S_SYNC;
               end else begin
                  st_nxt.state = S_SYNC;
               end
            end
         end
         S_CHAIN: begin
            if (mem_i.gnt) begin
               st_nxt.ptr   = mem_i.rdata;
               st_nxt.state = S_CAR;
            end
         end
         S_CAR: begin
            if (mem_i.gnt) begin
               if (mem_i.rdata != st_r.ptr) begin
                  st_nxt.carf  = 1'h1;
                  st_nxt.state = S_IDLE;
               end else begin
                  st_nxt.ptr   = st_r.ptr + 16'h0001;
                  st_nxt.state = S_HDR;
               end
            end
         end
         default: begin
            st_nxt.state = S_IDLE;
         end
      endcase
      if (end_tbl) begin
         if (st_r.state == S_WR && st_r.sc_irq) begin
            st_nxt.done = 1'h1;
         end
         st_nxt.state = st_nxt.sc_chain ? S_CHAIN : S_IDLE;
      end
      if (mem_err) begin
         st_nxt.par   = st_r.par | mem_i.par_err;
         st_nxt.prot  = st_r.prot | mem_i.prot_err;
         st_nxt.state = S_IDLE;
      end
      if (busy && cpu_parity_err) begin
         st_nxt.par   = 1'h1;
         st_nxt.state = S_IDLE;
      end
      if (sync_rise && sync_mode) begin
         st_nxt.sync_pend = 1'h1;
      end
      // Processor commands
      if (hit) begin
         case (cmd.func)
            FN_INIT: begin
               if (busy || (cmd.rmode[1:0] == 2'h3)) begin
                  st_nxt.rej   = 1'h1;
                  st_nxt.state = S_IDLE;
               end else begin
                  st_nxt.state     = S_HDR;
                  st_nxt.ptr       = cmd.addr;
                  st_nxt.rmode     = cmd.rmode;
                  st_nxt.par       = 1'h0;
                  st_nxt.prot      = 1'h0;
                  st_nxt.carf      = 1'h0;
                  st_nxt.sync_pend = 1'h0;
               end
            end
            FN_READ, FN_SENSE: begin
               if (is_dsw) begin
                  st_nxt.rsp.valid = 1'h1;
                  st_nxt.rsp.data  = input_device_status_word;
               end else if (busy && is_grp) begin
                  st_nxt.rej        = 1'h1;
                  st_nxt.rsp.valid  = 1'h1;
                  st_nxt.rsp.reject = 1'h1;
               end else begin
                  st_nxt.direct_program_transfer     = 1'h1;
                  st_nxt.dpc_rej = busy;
                  st_nxt.sel     = cmd.modifier;
                  st_nxt.grp_rd  = 1'h1;
                  if (busy && is_pi) begin
                     st_nxt.rej = 1'h1;
                  end
               end
            end
            FN_HALT: begin
               st_nxt.state     = S_IDLE;
               st_nxt.par       = 1'h0;
               st_nxt.prot      = 1'h0;
               st_nxt.done      = 1'h0;
               st_nxt.rej       = 1'h0;
               st_nxt.carf      = 1'h0;
               st_nxt.sync_pend = 1'h0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rsp         = st_r.rsp;
   assign group_sel   = st_r.sel;
   assign group_rd    = st_r.grp_rd;
   assign scan_irq    = st_r.done;
   assign cpu_hold    = busy && !sync_mode;
   // Request stays up while waiting; a higher channel simply withholds the grant
   assign mem_o.req   = (st_r.state inside {S_HDR, S_GRP, S_WR, S_CHAIN, S_CAR});
   assign mem_o.we    = (st_r.state == S_WR);
   assign mem_o.addr  = st_r.ptr;
   assign mem_o.wdata = st_r.data;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_init_abort: assert property (@(posedge clock) disable iff (!rst_b)
      hit && cmd.func == FN_INIT && busy |=> st_r.rej && st_r.state == S_IDLE)
      else $error("scan start during scan not rejected");
   chk_grp_refused: assert property (@(posedge clock) disable iff (!rst_b)
      hit && cmd.func == FN_READ && busy && is_grp && !is_dsw
      |=> rsp.valid && rsp.reject && !group_rd ##1 !rsp.valid)
      else $error("group read during scan not refused");
   chk_pi_completes: assert property (@(posedge clock) disable iff (!rst_b)
      hit && cmd.func == FN_READ && busy && is_pi
      |=> group_rd && st_r.rej ##1 rsp.valid && rsp.reject && rsp.data == $past(group_data))
      else $error("interrupt word read during scan lost");
   chk_parity_stop: assert property (@(posedge clock) disable iff (!rst_b)
      busy && cpu_parity_err && !(hit && cmd.func == FN_HALT) |=> !busy && st_r.par)
      else $error("parity error did not end scan");
   chk_sync_wait: assert property (@(posedge clock) disable iff (!rst_b)
      st_r.state == S_SYNC && sync_mode && !st_r.sync_pend && !hit && !cpu_parity_err |=> st_r.state == S_SYNC)
      else $error("sync paced transfer started without pulse");
   chk_done_set: assert property (@(posedge clock) disable iff (!rst_b)
      st_r.state == S_WR && mem_i.gnt && st_r.cnt == `DICS_CNT_W'(1) && st_r.sc_irq && !hit
      |=> scan_irq [*2])
      else $error("scan done not raised");
   chk_protect_end: assert property (@(posedge clock) disable iff (!rst_b)
      st_r.state == S_WR && mem_i.gnt && mem_i.prot_err && !hit |=> st_r.prot && !busy)
      else $error("protect error did not end scan");
   chk_sense_dsw: assert property (@(posedge clock) disable iff (!rst_b)
      hit && cmd.func == FN_SENSE && is_dsw
      |=> rsp.valid && !rsp.reject && rsp.data[`DICS_DSW_BUSY] == $past(busy))
      else $error("status sense answer wrong");
   chk_hold_off: assert property (@(posedge clock) disable iff (!rst_b)
      st_r.state == S_WR && mem_i.gnt && st_r.cnt == `DICS_CNT_W'(1) && st_r.sc_chain && !sync_mode
      && !mem_err && !cpu_parity_err && !hit |=> cpu_hold && st_r.state == S_CHAIN)
      else $error("processor released before chained scan ended");
endmodule : dics_scanner

//--- bench/dics_chan_model.sv
// Core storage and field input model facing the channel scanner
`timescale 1ns/10ps
module dics_chan_model
   import dics_pkg::*;
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_b,
   // Cycle steal channel
   input  wire dics_mreq_type mem_o,
   output dics_mrsp_type      mem_i,
   // Field inputs
   input  wire logic [6:0]    group_sel,
   input  wire logic          group_rd,
   output logic [15:0]        group_data,
   // Stall and fault controls
   input  wire logic [3:0]    delay,
   input  wire logic [7:0]    prot_addr,
   input  wire logic [7:0]    par_addr
);
   logic [15:0] mem [0:255];
   logic [3:0]  wait_cnt;
   // Unselected lines show the inverse, so a late sample never looks right
   assign group_data = group_rd ? {2'b10, group_sel, ~group_sel} : {2'b01, ~group_sel, group_sel};
   // One-cycle grant after delay stall cycles; read bus toggles when idle
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mem_i    <= '0;
         wait_cnt <= '0;
      end else if (!mem_i.gnt && mem_o.req && wait_cnt == delay) begin
         wait_cnt       <= '0;
         mem_i.gnt      <= 1'b1;
         mem_i.rdata    <= mem[mem_o.addr[7:0]];
         mem_i.par_err  <= mem_o.addr[7:0] == par_addr;
         mem_i.prot_err <= mem_o.we && mem_o.addr[7:0] == prot_addr;
         if (mem_o.we && mem_o.addr[7:0] != prot_addr) begin
            mem[mem_o.addr[7:0]] <= mem_o.wdata;
         end
      end else begin
         wait_cnt <= (mem_o.req && !mem_i.gnt) ? wait_cnt + 4'h1 : 4'h0;
         mem_i    <= '{gnt: 1'b0, rdata: ~mem_i.rdata, par_err: 1'b0, prot_err: 1'b0};
      end
   end
endmodule : dics_chan_model

//--- bench/test_digital_input_channel_scanner.sv
// Self-checking bench for the digital input channel scanner
`timescale 1ns/10ps
`include "dics_map.svh"
module test_digital_input_channel_scanner
   import dics_pkg::*;
;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic          clock;
   logic          rst_b;
   logic          cmd_valid;
   dics_cmd_type  cmd;
   dics_rsp_type  rsp;
   logic          cpu_parity_err;
   logic          cpu_hold;
   logic          scan_irq;
   dics_mreq_type mem_o;
   dics_mrsp_type mem_i;
   logic [6:0]    group_sel;
   logic          group_rd;
   logic [15:0]   group_data;
   logic          ext_sync;
   logic [3:0]    delay;
   logic [7:0]    prot_addr;
   logic [7:0]    par_addr;
   logic          held;
   logic [6:0]    dmods [4];
   int            miscompares;
   int            n_checks;
   int            n_rd = 0;
   int            i;
   localparam logic [15:0] bit_par  = 16'h0001 << `DICS_DSW_PAR;
   localparam logic [15:0] bit_prot = 16'h0001 << `DICS_DSW_PROT;
   localparam logic [15:0] bit_done = 16'h0001 << `DICS_DSW_DONE;
   localparam logic [15:0] bit_busy = 16'h0001 << `DICS_DSW_BUSY;
   localparam logic [15:0] bit_rej  = 16'h0001 << `DICS_DSW_REJ;
   localparam logic [15:0] bit_car  = 16'h0001 << `DICS_DSW_CAR;
   dics_scanner uut (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp),
                     .cpu_parity_err(cpu_parity_err), .cpu_hold(cpu_hold), .scan_irq(scan_irq), .mem_o(mem_o),
                     .mem_i(mem_i), .group_sel(group_sel), .group_rd(group_rd), .group_data(group_data),
                     .ext_sync(ext_sync));
   dics_chan_model ch (.clock(clock), .rst_b(rst_b), .mem_o(mem_o), .mem_i(mem_i), .group_sel(group_sel),
                       .group_rd(group_rd), .group_data(group_data), .delay(delay), .prot_addr(prot_addr),
                       .par_addr(par_addr));
   always #2 clock = ~clock;
   always @(posedge clock) begin
      if (group_rd === 1'b1) n_rd++;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [15:0] grp(input logic [6:0] s);
      return {2'b10, s, ~s};
   endfunction : grp
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic fail_wait;
      miscompares++;
      $display("ERROR at %0t: wait timed out", $time);
      wrap_up();
   endtask : fail_wait
   task automatic issue(input dics_func_type f, input logic [6:0] m, input logic [2:0] rm,
                        input logic [15:0] a, input logic b);
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd       <= '{func: f, area: `DICS_AREA, modifier: m, rmode: rm, addr: a, b15: b};
      @(posedge clock);
      cmd_valid <= 1'b0;
   endtask : issue
   task automatic rd(input dics_func_type f, input logic [6:0] m, input logic b, input logic [15:0] msk,
                     input logic [15:0] exp_d, input logic exp_r);
      int k;
      issue(f, m, 3'h0, 16'h0000, b);
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (rsp.valid !== 1'b1 && k < 4);
      if (rsp.valid !== 1'b1) fail_wait();
      chk(rsp.data & msk, exp_d);
      chk({15'h0000, rsp.reject}, {15'h0000, exp_r});
   endtask : rd
   task automatic scan(input logic [2:0] rm, input logic [15:0] a);
      int k;
      issue(FN_INIT, 7'h00, rm, a, 1'b0);
      held = 1'b0;
      for (k = 0; k < 3000; k++) begin
         @(negedge clock);
         if (cpu_hold !== 1'b1) break;
         held = 1'b1;
      end
      if (k == 3000) fail_wait();
   endtask : scan
   task automatic wait_irq;
      int k;
      for (k = 0; k < 200 && scan_irq !== 1'b1; k++) @(negedge clock);
      if (scan_irq !== 1'b1) fail_wait();
   endtask : wait_irq
   task automatic pulse;
      @(posedge clock);
      ext_sync <= 1'b1;
      repeat (4) @(posedge clock);
      ext_sync <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : pulse
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      cpu_parity_err = 1'b0;
      ext_sync = 1'b0;
      delay = 4'h0;
      prot_addr = 8'hFF;
      par_addr = 8'hFF;
      miscompares = 0;
      n_checks = 0;
      dmods = '{7'h40, 7'h7F, 7'h02, 7'h19};
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      rd(FN_SENSE, 7'h00, 1'b0, 16'hFFFF, 16'h0000, 1'b0);
      for (i = 0; i < 4; i++) rd(FN_READ, dmods[i], 1'b0, 16'hFFFF, grp(dmods[i]), 1'b0);
      $display("test direct reads done");
      ch.mem[8'h10] = 16'h8003;
      ch.mem[8'h11] = 16'h0045;
      delay <= 4'h2;
      scan(3'b010, 16'h0010);
      chk({15'h0000, held}, 16'h0001);
      for (i = 0; i < 3; i++) chk(ch.mem[8'h12 + i], grp(7'h45));
      wait_irq();
      rd(FN_SENSE, 7'h01, 1'b1, 16'hFFFF, bit_done, 1'b0);
      rd(FN_SENSE, 7'h00, 1'b0, 16'hFFFF, 16'h0000, 1'b0);
      chk({15'h0000, scan_irq}, 16'h0000);
      $display("test single scan done");
      ch.mem[8'h20] = 16'hC002;
      ch.mem[8'h21] = 16'h0050;
      ch.mem[8'h24] = 16'h0030;
      ch.mem[8'h30] = 16'h0030;
      ch.mem[8'h31] = 16'h8001;
      ch.mem[8'h32] = 16'h0041;
      delay <= 4'h0;
      scan(3'b001, 16'h0020);
      chk({15'h0000, held}, 16'h0001);
      chk(ch.mem[8'h22], grp(7'h50));
      chk(ch.mem[8'h23], grp(7'h51));
      chk(ch.mem[8'h33], grp(7'h41));
      rd(FN_SENSE, 7'h01, 1'b1, 16'hFFFF, bit_done, 1'b0);
      $display("test chained scan done");
      ch.mem[8'h40] = 16'h0002;
      ch.mem[8'h41] = 16'h0046;
      ch.mem[8'h43] = 16'h0003;
      ch.mem[8'h44] = 16'h1234;
      scan(3'b000, 16'h0040);
      chk(ch.mem[8'h42], grp(7'h46));
      chk(ch.mem[8'h44], 16'h0000);
      rd(FN_SENSE, 7'h00, 1'b0, 16'hFFFF, 16'h0000, 1'b0);
      $display("test random scan done");
      ch.mem[8'h50] = 16'h8002;
      ch.mem[8'h51] = 16'h0047;
      ch.mem[8'h52] = 16'h1234;
      scan(3'b110, 16'h0050);
      chk({15'h0000, held}, 16'h0000);
      repeat (20) @(posedge clock);
      chk(ch.mem[8'h52], 16'h1234);
      i = n_rd;
      rd(FN_READ, 7'h47, 1'b0, 16'hFFFF, 16'h0000, 1'b1);
      chk(16'(n_rd - i), 16'h0000);
      rd(FN_READ, 7'h02, 1'b0, 16'hFFFF, grp(7'h02), 1'b1);
      rd(FN_SENSE, 7'h01, 1'b1, 16'hFFFF, bit_busy | bit_rej, 1'b0);
      pulse();
      pulse();
      wait_irq();
      chk(ch.mem[8'h53], grp(7'h47));
      rd(FN_SENSE, 7'h01, 1'b1, 16'hFFFF, bit_done, 1'b0);
      $display("test sync scan done");
      scan(3'b100, 16'h0040);
      issue(FN_INIT, 7'h00, 3'b100, 16'h0040, 1'b0);
      rd(FN_SENSE, 7'h01, 1'b1, 16'hFFFF, bit_rej, 1'b0);
      scan(3'b101, 16'h0050);
      issue(FN_HALT, 7'h00, 3'h0, 16'h0000, 1'b0);
      rd(FN_SENSE, 7'h00, 1'b0, 16'hFFFF, 16'h0000, 1'b0);
      issue(FN_INIT, 7'h00, 3'b011, 16'h0010, 1'b0);
      rd(FN_SENSE, 7'h01, 1'b1, 16'hFFFF, bit_rej, 1'b0);
      scan(3'b110, 16'h0050);
      @(posedge clock);
      cpu_parity_err <= 1'b1;
      @(posedge clock);
      cpu_parity_err <= 1'b0;
      rd(FN_SENSE, 7'h00, 1'b0, 16'hFFFF, bit_par, 1'b0);
      $display("test abort done");
      prot_addr <= 8'h12;
      scan(3'b010, 16'h0010);
      rd(FN_SENSE, 7'h00, 1'b0, 16'hFFFF, bit_prot, 1'b0);
      prot_addr <= 8'hFF;
      par_addr <= 8'h11;
      scan(3'b010, 16'h0010);
      rd(FN_SENSE, 7'h00, 1'b0, 16'hFFFF, bit_par, 1'b0);
      par_addr <= 8'hFF;
      ch.mem[8'h30] = 16'h0031;
      scan(3'b001, 16'h0020);
      rd(FN_SENSE, 7'h00, 1'b1, bit_car, bit_car, 1'b0);
      $display("test error stops done");
      wrap_up();
   end
endmodule : test_digital_input_channel_scanner
